// *** testbench/can_bus_node.sv ***
// Far-side CAN node: wired-AND bus level and a free-running bit tick
`timescale 1ns/10ps
module can_bus_node #(
    parameter BIT_CYC = 4
)
(
    input wire clk_sys,
    input wire dut_tx,
    output wire bus_level,
    output reg bit_tick
);
    reg drive_low = 1'b0;
    reg [7:0] div_r = 8'h00;

    // Dominant wins; the bus idles recessive when nobody pulls it
    assign bus_level = dut_tx & ~drive_low;

    initial
        bit_tick = 1'b0;

    // Bit time runs free, so idle bits keep counting on a quiet bus
    always @(posedge clk_sys)
    begin
        div_r <= (div_r == BIT_CYC - 1) ? 8'h00 : div_r + 8'h01;
        bit_tick <= (div_r == 8'h00);
    end

    // Hold the bus at a level until told otherwise
    task hold_low(input v);
    begin
        @(posedge clk_sys);
        drive_low <= v;
    end
    endtask

    // Pull the bus dominant for n cycles, then release it
    task dominant(input integer n);
    begin
        @(posedge clk_sys);
        drive_low <= 1'b1;
        repeat (n) @(posedge clk_sys);
        drive_low <= 1'b0;
        #1;
    end
    endtask
endmodule

// *** testbench/can_pm_properties.sv ***
// Port-level checker for the CAN power-mode and interrupt block
`timescale 1ns/10ps
module can_pm_checker (
    input wire clk_sys,
    input wire rst,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire cpu_stop,
    input wire cpu_wait,
    input wire [2:0] tx_sent,
    input wire bus_transmit_line_r,
    input wire core_clk_en_r,
    input wire rx_internal_r,
    input wire shift_fg_r,
    input wire [2:0] tx_buffer_empty_flag_r,
    input wire wakeup_irq_r,
    input wire tx_irq_r
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // Out of reset the block is off with the bus released
    a_reset_state: assert property (
        $fell(rst) |-> !core_clk_en_r && bus_transmit_line_r && rx_internal_r
        && tx_buffer_empty_flag_r == 3'h7)
        else $error("reset state wrong");
    // Enable from the disabled state starts the clocks quickly
    a_enable_run: assert property (
        wr_stb && addr == 4'h1 && wdata[7] && !core_clk_en_r && !cpu_stop && !cpu_wait
        |-> ##[1:4] core_clk_en_r)
        else $error("enable did not start clocks");
    // A held stop leaves no clock running and the bus recessive
    a_stop_clk_off: assert property (
        cpu_stop [*4] |-> !core_clk_en_r && bus_transmit_line_r)
        else $error("clocks run during stop");
    // Clocks off means the transmit line is released
    a_off_tx_recessive: assert property (
        !core_clk_en_r [*2] |-> bus_transmit_line_r)
        else $error("transmit dominant while clocks off");
    // Nothing moves into the foreground buffer while asleep
    a_no_shift_asleep: assert property (
        !core_clk_en_r [*2] |-> !shift_fg_r)
        else $error("foreground shift while clocks off");
    // A finished buffer 0 reports empty
    a_tx_flag_set: assert property (
        tx_sent[0] |-> ##[1:2] tx_buffer_empty_flag_r[0])
        else $error("empty flag not set after send");
    // No pending flag means no transmit request
    a_tx_irq_idle: assert property (
        (tx_buffer_empty_flag_r == 3'h0) [*2] |-> !tx_irq_r)
        else $error("transmit irq without flag");
    // Wake interrupt only comes out of a clock-stopped mode
    a_wake_irq_sleep: assert property (
        $rose(wakeup_irq_r) |-> !$past(core_clk_en_r, 3))
        else $error("wake irq while running");
endmodule

bind can_power_mode_interrupt_ctrl can_pm_checker chk (.*);

// *** testbench/tb.sv ***
// Register-level tests of the CAN power-mode and interrupt block
`timescale 1ns/10ps
module tb;
    reg clk_sys = 1'b0;
    reg rst = 1'b1;
    reg [3:0] addr = 4'h0;
    reg [7:0] wdata = 8'h00;
    reg wr_stb = 1'b0;
    reg rd_stb = 1'b0;
    reg cpu_stop = 1'b0;
    reg cpu_wait = 1'b0;
    reg core_tx_bit = 1'b1;
    reg rx_busy = 1'b0;
    reg tx_busy = 1'b0;
    reg [2:0] tx_sent = 3'h0;
    reg rx_bg_pending = 1'b0;
    reg rx_fifo_overrun = 1'b0;
    reg [1:0] tx_err_state = 2'h0;
    reg [1:0] rx_err_state = 2'h0;
    reg bus_off = 1'b0;
    wire [7:0] rdata_r;
    wire [2:0] tx_buffer_empty_flag_r;
    wire bus_receive_line, bus_transmit_line_r, bit_tick, core_clk_en_r, rx_internal_r;
    wire shift_fg_r, abort_allowed_r, wakeup_irq_r, error_irq_r, rx_irq_r, tx_irq_r;
    integer errors = 0;
    integer cmp_count = 0;
    integer cycles = 0;
    integer k;

    can_power_mode_interrupt_ctrl #(.RECOV_CYC(8)) dut (.*);
    can_bus_node #(.BIT_CYC(4)) node (.clk_sys(clk_sys), .dut_tx(bus_transmit_line_r),
        .bus_level(bus_receive_line), .bit_tick(bit_tick));

    always #20 clk_sys = ~clk_sys;

    task check(input string nm, input [7:0] seen, input [7:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (seen !== exp)
        begin
            errors = errors + 1;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask

    task tally_and_finish;
    begin
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    // Hang guard: the tests need well under this many cycles
    always @(posedge clk_sys)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            errors = errors + 1;
            tally_and_finish;
        end
    end

    // Tasks start on an edge and end 1 ns after one, with outputs settled
    task wr(input [3:0] a, input [7:0] d);
    begin
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        #1;
    end
    endtask

    task rd(input [3:0] a, input [7:0] exp, input string nm);
    begin
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1;
        check(nm, rdata_r, exp);
    end
    endtask

    // Bounded wait for clocks running (w=0) or a foreground shift (w=1)
    task wait_hi(input integer w, input string nm);
        integer n;
    begin
        n = 0;
        while ((w == 0 ? core_clk_en_r : shift_fg_r) !== 1'b1 && n < 400)
        begin
            @(posedge clk_sys);
            #1;
            n = n + 1;
        end
        check(nm, {7'h0, n < 400}, 8'h01);
    end
    endtask

    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        rd(4'h0, 8'h00, "ctl0 reset");
        rd(4'h4, 8'h07, "tflg reset");
        rd(4'h6, 8'h00, "mode reset");
        rd(4'hf, 8'h00, "unmapped");
        check("clk_en reset", {7'h0, core_clk_en_r}, 8'h00);
        $display("test reset done");
        // Enable with glitch filter, then all interrupt enables
        wr(4'h1, 8'h84);
        wr(4'h3, 8'hc3);
        wr(4'h5, 8'h07);
        wait_hi(0, "enabled");
        rd(4'h1, 8'h84, "ctl1");
        check("tx_irq", {7'h0, tx_irq_r}, 8'h01);
        $display("test enable done");
        // Sleep asked while all three buffers are still scheduled
        @(posedge clk_sys);
        tx_busy <= 1'b1;
        wr(4'h4, 8'h07);
        rd(4'h4, 8'h00, "tflg scheduled");
        wr(4'h0, 8'h05);
        repeat (8) @(posedge clk_sys);
        rd(4'h0, 8'h05, "ctl0 busy");
        wr(4'h0, 8'h04);
        rd(4'h0, 8'h05, "ctl0 kept");
        @(posedge clk_sys);
        tx_sent <= 3'h7;
        tx_busy <= 1'b0;
        @(posedge clk_sys);
        tx_sent <= 3'h0;
        repeat (8) @(posedge clk_sys);
        rd(4'h0, 8'h07, "ctl0 asleep");
        rd(4'h4, 8'h07, "tflg sent");
        $display("test sleep done");
        // Asleep: core drives dominant, a message waits in the background
        @(posedge clk_sys);
        core_tx_bit <= 1'b0;
        rx_bg_pending <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        check("sleep tx", {7'h0, bus_transmit_line_r}, 8'h01);
        check("sleep clk", {7'h0, core_clk_en_r}, 8'h00);
        check("sleep shift", {7'h0, shift_fg_r}, 8'h00);
        check("sleep abort", {7'h0, abort_allowed_r}, 8'h00);
        @(posedge clk_sys);
        core_tx_bit <= 1'b1;
        node.dominant(3);
        repeat (12) @(posedge clk_sys);
        rd(4'h0, 8'h07, "ctl0 glitch");
        node.dominant(20);
        wait_hi(0, "woken");
        check("wake irq", {7'h0, wakeup_irq_r}, 8'h01);
        wait_hi(1, "deferred shift");
        check("abort back", {7'h0, abort_allowed_r}, 8'h01);
        @(posedge clk_sys);
        rx_bg_pending <= 1'b0;
        rd(4'h2, 8'h81, "rflg woken");
        check("rx irq", {7'h0, rx_irq_r}, 8'h01);
        wr(4'h2, 8'h80);
        rd(4'h2, 8'h01, "rflg one cleared");
        check("wake irq off", {7'h0, wakeup_irq_r}, 8'h00);
        wr(4'h2, 8'h01);
        rd(4'h2, 8'h00, "rflg clear");
        $display("test wake done");
        // Overrun and status change; overrun clear refused while it lasts
        @(posedge clk_sys);
        rx_fifo_overrun <= 1'b1;
        tx_err_state <= 2'h1;
        repeat (3) @(posedge clk_sys);
        rd(4'h2, 8'h46, "rflg error");
        check("err irq", {7'h0, error_irq_r}, 8'h01);
        wr(4'h2, 8'h02);
        rd(4'h2, 8'h46, "rflg held");
        @(posedge clk_sys);
        rx_fifo_overrun <= 1'b0;
        wr(4'h2, 8'h02);
        rd(4'h2, 8'h44, "rflg ovr off");
        $display("test error done");
        // Power-down by stop, then by wait with stop_in_wait set
        wr(4'h0, 8'h24);
        for (k = 0; k < 2; k = k + 1)
        begin
            @(posedge clk_sys);
            cpu_stop <= (k == 0);
            cpu_wait <= (k == 1);
            repeat (6) @(posedge clk_sys);
            #1;
            check("pdn clk", {7'h0, core_clk_en_r}, 8'h00);
            check("pdn tx", {7'h0, bus_transmit_line_r}, 8'h01);
            @(posedge clk_sys);
            cpu_stop <= 1'b0;
            cpu_wait <= 1'b0;
            wait_hi(0, "recovered");
        end
        $display("test power-down done");
        // Sleep with wake-up disabled: bus activity is masked
        wr(4'h0, 8'h01);
        repeat (8) @(posedge clk_sys);
        rd(4'h0, 8'h03, "ctl0 masked sleep");
        node.hold_low(1'b1);
        repeat (12) @(posedge clk_sys);
        #1;
        check("masked rx", {7'h0, rx_internal_r}, 8'h01);
        node.hold_low(1'b0);
        rd(4'h6, 8'h03, "mode locked");
        // Stop taken from sleep returns to sleep with no recovery
        @(posedge clk_sys);
        cpu_stop <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        check("sleep pdn tx", {7'h0, bus_transmit_line_r}, 8'h01);
        @(posedge clk_sys);
        cpu_stop <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd(4'h6, 8'h03, "mode back asleep");
        wr(4'h0, 8'h00);
        wait_hi(0, "request cleared");
        rd(4'h0, 8'h00, "ctl0 awake");
        $display("test masked sleep done");
        tally_and_finish;
    end
endmodule

// *** verilog/can_pm_map.vh ***
// Register offsets, field positions, reset values and timing for the CAN power/interrupt block
`ifndef CAN_PM_MAP_VH
`define CAN_PM_MAP_VH
// Register offsets (word index on the plain register port)
`define CTL0_ADDR 4'h0
`define CTL1_ADDR 4'h1
`define RFLG_ADDR 4'h2
`define RIER_ADDR 4'h3
`define TFLG_ADDR 4'h4
`define TIER_ADDR 4'h5
`define MODE_ADDR 4'h6
// control_reg_zero fields
`define C0_SLEEP_REQUEST 0
`define C0_SLEEP_ACKNOWLEDGE 1
`define C0_WAKEUP_ENABLE 2
`define C0_WAIT 5
// control_reg_one fields
`define C1_WAKEUP_FILTER_SELECT 2
`define C1_ENABLE 7
// receive_flag_reg fields
`define RF_RXF 0
`define RF_OVR 1
`define RF_TST_LO 2
`define RF_TST_HI 3
`define RF_RST_LO 4
`define RF_RST_HI 5
`define RF_CSC 6
`define RF_WUP 7
// Reset values
`define CTL0_RST 8'h00
`define CTL1_RST 8'h00
`define TFLG_RST 3'h7
// Mode codes; the mode register shows the state_r encoding instead (sleep reads 3)
`define MODE_DIS 3'h0
`define MODE_NORM 3'h1
`define MODE_SLEEP 3'h2
`define MODE_PDN 3'h3
`define MODE_RECOV 3'h4
`define MODE_SYNC 3'h5
// Timing
`define SYNC_DLY_CYC 4'h3
`define RECOV_DLY_CYC 8'h10
`define IDLE_BITS 8'h0b
`define GLITCH_CYC 8'h08
`define BUSOFF_SEQS 8'h80
`endif

// *** verilog/can_power_mode_interrupt_ctrl.v ***
// Power-mode sequencing, wake-up and interrupt flags of a CAN controller
`timescale 1ns/10ps
`include "can_pm_map.vh"
module can_power_mode_interrupt_ctrl #(
    parameter RECOV_CYC = `RECOV_DLY_CYC
)
(
    input wire clk_sys,
    input wire rst,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [7:0] rdata_r,
    input wire cpu_stop,
    input wire cpu_wait,
    input wire bus_receive_line,
    output reg bus_transmit_line_r,
    input wire core_tx_bit,
    input wire bit_tick,
    input wire rx_busy,
    input wire tx_busy,
    input wire [2:0] tx_sent,
    input wire rx_bg_pending,
    input wire rx_fifo_overrun,
    input wire [1:0] tx_err_state,
    input wire [1:0] rx_err_state,
    input wire bus_off,
    output reg core_clk_en_r,
    output reg rx_internal_r,
    output reg shift_fg_r,
    output reg abort_allowed_r,
    output reg [2:0] tx_buffer_empty_flag_r,
    output reg wakeup_irq_r,
    output reg error_irq_r,
    output reg rx_irq_r,
    output reg tx_irq_r
);
    localparam S_DIS = 3'h0;
    localparam S_NORM = 3'h1;
    localparam S_WAIT_SLP = 3'h2;
    localparam S_SLEEP = 3'h3;
    localparam S_PDN = 3'h4;
    localparam S_RECOV = 3'h5;
    localparam S_RESYNC = 3'h6;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [7:0] ctl0_r;
    reg [7:0] ctl1_r;
    reg [7:0] rflg_r;
    reg [7:0] rier_r;
    reg [2:0] tier_r;
    reg [3:0] sync_cnt_r;
    reg [7:0] recov_cnt_r;
    reg pdn_from_sleep_r;
    reg [1:0] tst_prev_r;
    reg [1:0] rst_prev_r;
    reg rx_full_r;
    wire wake_det;
    wire idle_run_done;
    wire [7:0] busoff_seqs;

    wire sleep_request = ctl0_r[`C0_SLEEP_REQUEST];
    wire wakeup_enable = ctl0_r[`C0_WAKEUP_ENABLE];
    wire stop_in_wait = ctl0_r[`C0_WAIT];
    wire module_enable = ctl1_r[`C1_ENABLE];
    wire pdn_cond = cpu_stop || (cpu_wait && stop_in_wait);
    wire in_sleep = (state_r == S_SLEEP);
    wire wr_hit0 = wr_stb && (addr == `CTL0_ADDR);
    // One shift per queued message: the full flag lands a cycle after the
    // shift pulse, so the pulse itself also blocks the next shift. Without
    // this a level-held pending input would shift the same message twice.
    wire shift_ok = (state_r == S_NORM) && rx_bg_pending && !rflg_r[`RF_RXF]
        && !rx_full_r;

    // Maps bus counter state to the two-bit range field
    function [1:0] range_code;
        input [1:0] st;
        begin
            range_code = st;
        end
    endfunction

    // Wake detection armed only where a wake makes sense
    wake_filter #(
        .CW(8)
    ) u_wake (
        .clk_sys(clk_sys),
        .rst(rst),
        .arm((in_sleep || (state_r == S_PDN && pdn_from_sleep_r)) && wakeup_enable),
        .filter_on(ctl1_r[`C1_WAKEUP_FILTER_SELECT]),
        .rx_in(bus_receive_line),
        .wake_r(wake_det)
    );

    // Shared counter: eleven-bit idle runs for resync and bus-off recovery
    recessive_counter u_idle (
        .clk_sys(clk_sys),
        .rst(rst),
        .run((state_r == S_RESYNC) || (bus_off && state_r == S_NORM)),
        .clear(!bus_off && state_r != S_RESYNC),
        .bit_tick(bit_tick),
        .rx_bit(bus_receive_line),
        .run_done_r(idle_run_done),
        .seq_cnt_r(busoff_seqs)
    );

    // Mode sequencing; power-down has priority next after disable
    // Disable beats everything so software can always park the block.
    // Limitation: a sleep request that never sees the buffers drain keeps
    // the block waiting; software must watch the acknowledge bit.
    always @*
    begin
        state_nxt = state_r;
        if (!module_enable)
            state_nxt = S_DIS;
        else if (pdn_cond && state_r != S_PDN)
            state_nxt = S_PDN;
        else
        begin
            case (state_r)
                S_DIS:
                    state_nxt = S_NORM;
                S_NORM:
                    if (sleep_request)
                        state_nxt = S_WAIT_SLP;
                S_WAIT_SLP:
                    // Buffers must drain and the bus go idle first
                    if (tx_buffer_empty_flag_r == 3'h7 && !tx_busy && !rx_busy
                        && sync_cnt_r == `SYNC_DLY_CYC)
                        state_nxt = S_SLEEP;
                S_SLEEP:
                    if (wake_det || !sleep_request)
                        state_nxt = S_RESYNC;
                S_PDN:
                    if (!pdn_cond)
                        state_nxt = pdn_from_sleep_r ?
                            (wake_det ? S_RESYNC : S_SLEEP) : S_RECOV;
                S_RECOV:
                    if (recov_cnt_r == RECOV_CYC[7:0])
                        state_nxt = S_NORM;
                S_RESYNC:
                    if (idle_run_done)
                        state_nxt = S_NORM;
                default:
                    state_nxt = S_DIS;
            endcase
        end
    end

    // State, counters and control registers
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_r <= S_DIS;
            ctl0_r <= `CTL0_RST;
            ctl1_r <= `CTL1_RST;
            rier_r <= 8'h00;
            tier_r <= 3'h0;
            sync_cnt_r <= 4'h0;
            recov_cnt_r <= 8'h00;
            pdn_from_sleep_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_r == S_WAIT_SLP && sync_cnt_r != `SYNC_DLY_CYC)
                sync_cnt_r <= sync_cnt_r + 4'h1;
            else if (state_r != S_WAIT_SLP)
                sync_cnt_r <= 4'h0;
            recov_cnt_r <= (state_r == S_RECOV) ? recov_cnt_r + 8'h01 : 8'h00;
            if (state_nxt == S_PDN && state_r != S_PDN)
                pdn_from_sleep_r <= in_sleep;
            if (wr_stb && addr == `CTL1_ADDR)
                ctl1_r <= wdata;
            if (wr_stb && addr == `RIER_ADDR)
                rier_r <= wdata;
            if (wr_stb && addr == `TIER_ADDR)
                tier_r <= wdata[2:0];
            if (wr_hit0)
            begin
                ctl0_r[`C0_WAKEUP_ENABLE] <= wdata[`C0_WAKEUP_ENABLE];
                ctl0_r[`C0_WAIT] <= wdata[`C0_WAIT];
                // Request may only drop once acknowledged
                if (wdata[`C0_SLEEP_REQUEST] || in_sleep)
                    ctl0_r[`C0_SLEEP_REQUEST] <= wdata[`C0_SLEEP_REQUEST];
            end
            if (state_r == S_SLEEP && state_nxt == S_RESYNC)
                ctl0_r[`C0_SLEEP_REQUEST] <= 1'b0;
            ctl0_r[`C0_SLEEP_ACKNOWLEDGE] <= (state_nxt == S_SLEEP);
        end
    end

    // Flags: hardware set wins over a write-one clear
    // Clears are applied first and sets after them in the same process,
    // so an event landing on the clear cycle is never lost.
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            rflg_r <= 8'h00;
            tx_buffer_empty_flag_r <= `TFLG_RST;
            tst_prev_r <= 2'h0;
            rst_prev_r <= 2'h0;
        end
        else
        begin
            tst_prev_r <= range_code(tx_err_state);
            rst_prev_r <= range_code(rx_err_state);
            rflg_r[`RF_TST_HI:`RF_TST_LO] <= range_code(tx_err_state);
            rflg_r[`RF_RST_HI:`RF_RST_LO] <= range_code(rx_err_state);
            if (wr_stb && addr == `RFLG_ADDR)
            begin
                if (wdata[`RF_WUP])
                    rflg_r[`RF_WUP] <= 1'b0;
                if (wdata[`RF_CSC])
                    rflg_r[`RF_CSC] <= 1'b0;
                if (wdata[`RF_OVR] && !rx_fifo_overrun)
                    rflg_r[`RF_OVR] <= 1'b0;
                if (wdata[`RF_RXF])
                    rflg_r[`RF_RXF] <= 1'b0;
            end
            if (wake_det && rier_r[`RF_WUP])
                rflg_r[`RF_WUP] <= 1'b1;
            if (tst_prev_r != range_code(tx_err_state)
                || rst_prev_r != range_code(rx_err_state))
                rflg_r[`RF_CSC] <= 1'b1;
            if (rx_fifo_overrun)
                rflg_r[`RF_OVR] <= 1'b1;
            if (rx_full_r)
                rflg_r[`RF_RXF] <= 1'b1;
            // Empty flags cleared by software schedule a buffer
            if (wr_stb && addr == `TFLG_ADDR)
                tx_buffer_empty_flag_r <= tx_buffer_empty_flag_r & ~wdata[2:0] | tx_sent;
            else
                tx_buffer_empty_flag_r <= tx_buffer_empty_flag_r | tx_sent;
        end
    end

    // Outputs toward the protocol core and the bus
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            core_clk_en_r <= 1'b0;
            bus_transmit_line_r <= 1'b1;
            rx_internal_r <= 1'b1;
            shift_fg_r <= 1'b0;
            abort_allowed_r <= 1'b0;
            rx_full_r <= 1'b0;
        end
        else
        begin
            core_clk_en_r <= (state_nxt == S_NORM) || (state_nxt == S_WAIT_SLP)
                || (state_nxt == S_RESYNC);
            // Transmit line recessive outside active modes
            bus_transmit_line_r <= (state_nxt == S_NORM || state_nxt == S_WAIT_SLP)
                ? core_tx_bit : 1'b1;
            rx_internal_r <= (in_sleep && !wakeup_enable) ? 1'b1 : bus_receive_line;
            // Deferred shift and aborts resume only once awake
            shift_fg_r <= shift_ok;
            rx_full_r <= shift_ok;
            abort_allowed_r <= (state_r == S_NORM);
        end
    end

    // Interrupt request lines
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            wakeup_irq_r <= 1'b0;
            error_irq_r <= 1'b0;
            rx_irq_r <= 1'b0;
            tx_irq_r <= 1'b0;
        end
        else
        begin
            wakeup_irq_r <= rflg_r[`RF_WUP] && rier_r[`RF_WUP] && wakeup_enable;
            error_irq_r <= (rflg_r[`RF_CSC] && rier_r[`RF_CSC])
                || (rflg_r[`RF_OVR] && rier_r[`RF_OVR]);
            rx_irq_r <= rflg_r[`RF_RXF] && rier_r[`RF_RXF];
            tx_irq_r <= |(tx_buffer_empty_flag_r & tier_r);
        end
    end

    // Register read port, data one cycle after strobe
    // Data return to zero outside the answer cycle, so a stale value
    // can never be mistaken for a fresh read.
    always @(posedge clk_sys)
    begin
        if (rst)
            rdata_r <= 8'h00;
        else if (!rd_stb)
            rdata_r <= 8'h00;
        else if (addr == `CTL0_ADDR)
            rdata_r <= ctl0_r;
        else if (addr == `CTL1_ADDR)
            rdata_r <= ctl1_r;
        else if (addr == `RFLG_ADDR)
            rdata_r <= rflg_r;
        else if (addr == `RIER_ADDR)
            rdata_r <= rier_r;
        else if (addr == `TFLG_ADDR)
            rdata_r <= {5'h00, tx_buffer_empty_flag_r};
        else if (addr == `TIER_ADDR)
            rdata_r <= {5'h00, tier_r};
        else if (addr == `MODE_ADDR)
            rdata_r <= {busoff_seqs[7], 4'h0, state_r};
        else
            rdata_r <= 8'h00;
    end
endmodule

// *** verilog/recessive_counter.v ***
// Counts runs of consecutive recessive bits and completed runs
`timescale 1ns/10ps
`include "can_pm_map.vh"
module recessive_counter (
    input wire clk_sys,
    input wire rst,
    input wire run,
    input wire clear,
    input wire bit_tick,
    input wire rx_bit,
    output reg run_done_r,
    output reg [7:0] seq_cnt_r
);
    reg [7:0] bit_cnt_r;
    // Freezes while run is low so a paused count resumes later
    always @(posedge clk_sys)
    begin
        if (rst || clear)
        begin
            bit_cnt_r <= 8'h00;
            seq_cnt_r <= 8'h00;
            run_done_r <= 1'b0;
        end
        else
        begin
            run_done_r <= 1'b0;
            if (run && bit_tick)
            begin
                if (!rx_bit)
                    bit_cnt_r <= 8'h00;
                else if (bit_cnt_r == `IDLE_BITS - 8'h01)
                begin
                    bit_cnt_r <= 8'h00;
                    run_done_r <= 1'b1;
                    if (seq_cnt_r != `BUSOFF_SEQS)
                        seq_cnt_r <= seq_cnt_r + 8'h01;
                end
                else
                    bit_cnt_r <= bit_cnt_r + 8'h01;
            end
        end
    end
endmodule

// *** verilog/wake_filter.v ***
// Wake detector on the receive line with optional low-pass glitch filter
`timescale 1ns/10ps
`include "can_pm_map.vh"
module wake_filter #(
    parameter CW = 8
)
(
    input wire clk_sys,
    input wire rst,
    input wire arm,
    input wire filter_on,
    input wire rx_in,
    output reg wake_r
);
    reg [CW-1:0] low_cnt_r;
    // Dominant level must persist GLITCH_CYC cycles when the filter is on
    always @(posedge clk_sys)
    begin
        if (rst || !arm)
        begin
            low_cnt_r <= {CW{1'b0}};
            wake_r <= 1'b0;
        end
        else if (rx_in)
        begin
            low_cnt_r <= {CW{1'b0}};
            wake_r <= 1'b0;
        end
        else
        begin
            if (low_cnt_r != `GLITCH_CYC)
                low_cnt_r <= low_cnt_r + 1'b1;
            wake_r <= !filter_on || (low_cnt_r == `GLITCH_CYC - 8'h01);
        end
    end
endmodule
